// ==== include/optic_link.sv ====
// Pin and serial access link between host and optical module
`timescale 1ns/1ps
`default_nettype none
interface optic_link;
  logic       tx_off;
  logic       laser_fault;
  logic       receive_signal_lost;
  logic       speed_choice_first;
  logic       speed_choice_second;
  logic       acc_valid;
  logic       acc_write;
  logic       acc_page;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic       acc_ack;
  logic [7:0] acc_rdata;
  logic       dev_busy;

  modport device (
    input  tx_off, speed_choice_first, speed_choice_second,
    input  acc_valid, acc_write, acc_page, acc_addr, acc_wdata,
    output laser_fault, receive_signal_lost, acc_ack, acc_rdata, dev_busy
  );
  modport host (
    output tx_off, speed_choice_first, speed_choice_second,
    output acc_valid, acc_write, acc_page, acc_addr, acc_wdata,
    input  laser_fault, receive_signal_lost, acc_ack, acc_rdata, dev_busy
  );
endinterface : optic_link
`default_nettype wire

// ==== include/optic_pkg.sv ====
// Shared constants for the optical module control link
package optic_pkg;
  localparam int CLK_MHZ = 50;
  localparam int TIMER_W = 20;

  localparam int T_FAULT_HOLD_US = 10;
  localparam logic [19:0] FAULT_HOLD_CYC = 20'(T_FAULT_HOLD_US * CLK_MHZ);
  localparam int T_BUS_IDLE_US = 20;
  localparam logic [19:0] BUS_IDLE_CYC = 20'(T_BUS_IDLE_US * CLK_MHZ);
  localparam int F_SERIAL_KHZ = 100;
  localparam logic [19:0] SERIAL_PERIOD_CYC =
    20'((CLK_MHZ * 1000 + F_SERIAL_KHZ - 1) / F_SERIAL_KHZ);
  localparam logic [19:0] ACCESS_GAP_CYC = BUS_IDLE_CYC + SERIAL_PERIOD_CYC;
  localparam int T_WRITE_MS = 10;
  localparam int WRITE_WAIT_CYC = T_WRITE_MS * 1000 * CLK_MHZ;

  localparam logic [19:0] DEV_INIT_CYC  = 20'h00020;
  localparam logic [19:0] DEV_READY_CYC = 20'h00010;
  localparam logic [19:0] DEV_WRITE_CYC = 20'h00008;

  localparam logic [7:0] STATUS_CONTROL_ADDR   = 8'h6E;
  localparam logic [7:0] EXTENDED_CONTROL_ADDR = 8'h76;
  localparam int SC_TXOFF_PIN = 7;
  localparam int SC_SOFT_OFF  = 6;
  localparam int SC_SP2_PIN   = 5;
  localparam int SC_SP1_PIN   = 4;
  localparam int SC_SOFT_SP   = 3;
  localparam int SC_FAULT     = 2;
  localparam int SC_LOST      = 1;
  localparam int SC_READY     = 0;
  localparam int EC_SOFT_SP   = 3;
  localparam logic [7:0] ID_FIRST_BYTE = 8'h5A; // Arbitrary identification byte

  localparam logic [7:0] H_CTRL     = 8'h00;
  localparam logic [7:0] H_STATUS   = 8'h04;
  localparam logic [7:0] H_IRQ_STAT = 8'h08;
  localparam logic [7:0] H_IRQ_MASK = 8'h0C;
  localparam logic [7:0] H_ACCESS   = 8'h10;
  localparam logic [7:0] H_RDATA    = 8'h14;
  localparam int CTRL_OFF    = 0;
  localparam int CTRL_SP1    = 1;
  localparam int CTRL_SP2    = 2;
  localparam int CTRL_FRESET = 3;
  localparam int ACC_WRITE   = 16;
  localparam int ACC_PAGE    = 17;
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_LOST    = 1;
  localparam int IRQ_FOUND   = 2;
  localparam int IRQ_DONE    = 3;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ISSUE, H_ACK} host_state_e;
endpackage : optic_pkg

// ==== testbench/optic_monitor.sv ====
// Protocol checker for the host to module control link
`timescale 1ns/1ps
`default_nettype none
module optic_monitor
  import optic_pkg::*;
(
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       tx_off,
  input wire logic       laser_fault,
  input wire logic       receive_signal_lost,
  input wire logic       speed_choice_first,
  input wire logic       speed_choice_second,
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire logic       acc_page,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic       acc_ack,
  input wire logic [7:0] acc_rdata,
  input wire logic       dev_busy
);
  logic [19:0] gap_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Cycles since the last acknowledge, saturating
  always_ff @(posedge clock) begin
    if (!nrst) gap_cnt <= 20'hFFFFF;
    else if (acc_ack) gap_cnt <= 20'h00000;
    else if (gap_cnt != 20'hFFFFF) gap_cnt <= gap_cnt + 20'h00001;
  end
  property p_ready;
    $rose(nrst) |-> ##[1:20] !dev_busy; endproperty
  a_ready: assert property (p_ready) else $error("device not ready after reset");
  property p_ack_one;
    acc_valid && !dev_busy |=> acc_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("access not acknowledged");
  property p_ack_single;
    acc_ack |=> !acc_ack; endproperty
  a_ack_single: assert property (p_ack_single) else $error("acknowledge too long");
  property p_write_cycle;
    acc_ack && acc_write |=> dev_busy ##[1:12] !dev_busy; endproperty
  a_write_cycle: assert property (p_write_cycle) else $error("write cycle bound");
  property p_gap;
    acc_valid |-> gap_cnt >= BUS_IDLE_CYC; endproperty
  a_gap: assert property (p_gap) else $error("idle gap too short");
  property p_valid_one;
    acc_valid |=> !acc_valid; endproperty
  a_valid_one: assert property (p_valid_one) else $error("access strobe too long");
  property p_rdata_hold;
    !(acc_ack && !acc_write) |-> $stable(acc_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_fault_clear;
    laser_fault && tx_off |-> ##[1:8] !laser_fault; endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
  c_diag_write: cover property (acc_valid && acc_write && acc_page && acc_wdata != 8'h00);
  c_id_read: cover property (acc_valid && !acc_page && acc_addr == 8'h00);
  c_both_fast: cover property (speed_choice_first && speed_choice_second);
  c_lost: cover property ($rose(receive_signal_lost));
endmodule : optic_monitor
`default_nettype wire

// ==== testbench/optical_module_control_status_tb.sv ====
// Testbench joining host end and module end over the control link
`timescale 1ns/1ps
`default_nettype none
module optical_module_control_status_tb
  import optic_pkg::*;
;
  logic        clock;
  logic        nrst;
  logic        laser_fault_sense;
  logic        optical_present;
  logic        monitor_ok;
  logic        wr;
  logic        rd;
  logic [7:0]  address;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        irq;
  logic        laser_emit;
  logic        tx_cdr_engage;
  logic        rx_cdr_engage;
  logic [31:0] r;
  int          n_mismatch;
  int          total_checks;

  optic_link optic_link_i ();
  module_end module_end_i (.clock(clock), .nrst(nrst), .link(optic_link_i.device),
    .laser_fault_sense(laser_fault_sense), .optical_present(optical_present),
    .monitor_ok(monitor_ok), .laser_emit(laser_emit), .tx_cdr_engage(tx_cdr_engage),
    .rx_cdr_engage(rx_cdr_engage));
  // Write wait kept above the bus idle minimum
  host_end #(.WRITE_WAIT(1200)) host_end_i (.clock(clock), .nrst(nrst),
    .link(optic_link_i.host), .address(address), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  optic_monitor optic_monitor_i (.clock(clock), .nrst(nrst), .tx_off(optic_link_i.tx_off),
    .laser_fault(optic_link_i.laser_fault),
    .receive_signal_lost(optic_link_i.receive_signal_lost),
    .speed_choice_first(optic_link_i.speed_choice_first),
    .speed_choice_second(optic_link_i.speed_choice_second),
    .acc_valid(optic_link_i.acc_valid), .acc_write(optic_link_i.acc_write),
    .acc_page(optic_link_i.acc_page), .acc_addr(optic_link_i.acc_addr),
    .acc_wdata(optic_link_i.acc_wdata), .acc_ack(optic_link_i.acc_ack),
    .acc_rdata(optic_link_i.acc_rdata), .dev_busy(optic_link_i.dev_busy));

  always #10 clock = ~clock;

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    wdata   <= d;
    wr      <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    rd      <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Bounded poll of a host register field
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] d;
    int          k;
    for (k = 0; k < 3000; k++) begin
      rd_reg(a, d);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask : poll

  task automatic acc(input logic w, input logic pg, input logic [7:0] a,
                     input logic [7:0] dat, output logic [31:0] d);
    poll(H_STATUS, 32'hC, 32'h0);
    wr_reg(H_ACCESS, {14'h0, pg, w, a, dat});
    poll(H_IRQ_STAT, 32'h8, 32'h8);
    wr_reg(H_IRQ_STAT, 32'h8);
    poll(H_STATUS, 32'hC, 32'h0);
    rd_reg(H_RDATA, d);
  endtask : acc

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    laser_fault_sense = 1'b0;
    optical_present = 1'b1;
    monitor_ok = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    address = 8'h00;
    wdata = 32'h0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    wait_cyc(40);
    chk1(laser_emit, 1'b1);
    chk1(tx_cdr_engage | rx_cdr_engage, 1'b0);
    rd_reg(H_IRQ_STAT, r);
    chk(r, 32'h4);
    wr_reg(H_IRQ_STAT, 32'h4);
    wr_reg(H_IRQ_MASK, 32'hF);
    @(posedge clock) laser_fault_sense <= 1'b1;
    wait_cyc(6);
    chk1(optic_link_i.laser_fault, 1'b1);
    chk1(laser_emit, 1'b0);
    rd_reg(H_STATUS, r);
    chk(r & 32'h3, 32'h1);
    chk1(irq, 1'b1);
    @(posedge clock) laser_fault_sense <= 1'b0;
    wr_reg(H_IRQ_STAT, 32'h1);
    rd_reg(H_IRQ_STAT, r);
    chk(r, 32'h0);
    wait_cyc(10);
    chk1(laser_emit, 1'b0);
    wr_reg(H_CTRL, 32'h8);
    rd_reg(H_CTRL, r);
    chk(r, 32'h8);
    chk1(optic_link_i.tx_off, 1'b1);
    wait_cyc(600);
    chk1(optic_link_i.laser_fault, 1'b0);
    chk1(laser_emit, 1'b1);
    @(posedge clock) optical_present <= 1'b0;
    wait_cyc(6);
    chk1(optic_link_i.receive_signal_lost, 1'b1);
    @(posedge clock) optical_present <= 1'b1;
    wait_cyc(6);
    chk1(optic_link_i.receive_signal_lost, 1'b0);
    rd_reg(H_IRQ_STAT, r);
    chk(r, 32'h6);
    wr_reg(H_IRQ_MASK, 32'h0);
    wait_cyc(1);
    chk1(irq, 1'b0);
    wr_reg(H_IRQ_MASK, 32'hF);
    wr_reg(H_IRQ_STAT, 32'h6);
    wait_cyc(1);
    chk1(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(H_CTRL, 32'(i) << 1);
      wait_cyc(4);
      chk1(rx_cdr_engage, i[0]);
      chk1(tx_cdr_engage, i[1]);
    end
    wr_reg(H_CTRL, 32'h1);
    wait_cyc(3);
    chk1(laser_emit, 1'b0);
    wr_reg(H_CTRL, 32'h0);
    wait_cyc(40);
    chk1(laser_emit, 1'b1);
    acc(1'b1, 1'b1, STATUS_CONTROL_ADDR, 8'h40, r);
    wait_cyc(3);
    chk1(laser_emit, 1'b0);
    acc(1'b0, 1'b1, STATUS_CONTROL_ADDR, 8'h00, r);
    chk(r, 32'h41);
    acc(1'b1, 1'b1, STATUS_CONTROL_ADDR, 8'h08, r);
    wait_cyc(40);
    chk1(laser_emit, 1'b1);
    chk1(rx_cdr_engage, 1'b1);
    chk1(tx_cdr_engage, 1'b0);
    acc(1'b1, 1'b1, EXTENDED_CONTROL_ADDR, 8'h08, r);
    wait_cyc(3);
    chk1(tx_cdr_engage, 1'b1);
    @(posedge clock) monitor_ok <= 1'b0;
    optical_present <= 1'b0;
    laser_fault_sense <= 1'b1;
    wait_cyc(6);
    acc(1'b0, 1'b1, STATUS_CONTROL_ADDR, 8'h00, r);
    chk(r, 32'h0E);
    chk(r & 32'h2, 32'h2);
    acc(1'b0, 1'b0, 8'h00, 8'h00, r);
    chk(r, {24'h0, ID_FIRST_BYTE});
    rd_reg(8'h20, r);
    chk(r, 32'h0);
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    $display("Error at %0t: run did not finish", $time);
    final_report();
  end
endmodule : optical_module_control_status_tb
`default_nettype wire

// ==== verilog/hold_timer.sv ====
// Loadable down counter with expiry flag
`timescale 1ns/1ps
`default_nettype none
module hold_timer
  import optic_pkg::*;
#(
  parameter logic [19:0] RESET_COUNT = 20'h00000
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [19:0] load,
  output logic             expired
);
  logic [19:0] count;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= RESET_COUNT;
    end else if (start) begin
      count <= load;
    end else if (count != 20'h00000) begin
      count <= count - 20'h00001;
    end
  end

  assign expired = (count == 20'h00000);
endmodule : hold_timer
`default_nettype wire

// ==== verilog/host_end.sv ====
// Host controller end: drives module pins and serial accesses
`timescale 1ns/1ps
`default_nettype none
module host_end
  import optic_pkg::*;
#(
  parameter int WRITE_WAIT = WRITE_WAIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  optic_link.host          link,
  input  wire logic [7:0]  address,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq
);
  host_state_e state;
  logic [2:0]  ctrl;
  logic        freset;
  logic        hold_start;
  logic        hold_done;
  logic        gap_start;
  logic        gap_done;
  logic [19:0] gap_load;
  logic [17:0] acc;
  logic [7:0]  last_read;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [3:0]  events;
  logic        prev_fault;
  logic        prev_lost;
  logic        busy;
  logic        acc_take;

  assign busy       = (state != H_IDLE);
  assign acc_take   = wr & (address == H_ACCESS) & ~busy;
  assign hold_start = wr & (address == H_CTRL) & wdata[CTRL_FRESET] & ~freset;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl <= 3'h0;
    end else if (wr && address == H_CTRL) begin
      ctrl <= wdata[CTRL_SP2:CTRL_OFF];
    end
  end

  hold_timer hold_tmr (
    .clock   (clock),
    .nrst    (nrst),
    .start   (hold_start),
    .load    (FAULT_HOLD_CYC),
    .expired (hold_done)
  );

  // Fault reset keeps tx_off high for the full hold time
  always_ff @(posedge clock) begin
    if (!nrst) begin
      freset <= 1'b0;
    end else if (hold_start) begin
      freset <= 1'b1;
    end else if (hold_done) begin
      freset <= 1'b0;
    end
  end

  assign link.tx_off              = ctrl[CTRL_OFF] | freset;
  assign link.speed_choice_first  = ctrl[CTRL_SP1];
  assign link.speed_choice_second = ctrl[CTRL_SP2];

  assign gap_start = (state == H_ACK) & link.acc_ack;
  assign gap_load  = acc[ACC_WRITE] ? 20'(WRITE_WAIT) : ACCESS_GAP_CYC;

  hold_timer gap_tmr (
    .clock   (clock),
    .nrst    (nrst),
    .start   (gap_start),
    .load    (gap_load),
    .expired (gap_done)
  );

  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc <= 18'h00000;
    end else if (acc_take) begin
      acc <= wdata[17:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= H_IDLE;
    end else begin
      case (state)
        H_IDLE:  if (acc_take) state <= H_WAIT;
        H_WAIT:  if (gap_done && !link.dev_busy) state <= H_ISSUE;
        H_ISSUE: state <= H_ACK;
        H_ACK:   if (link.acc_ack) state <= H_IDLE;
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.acc_valid = (state == H_ISSUE);
  assign link.acc_write = acc[ACC_WRITE];
  assign link.acc_page  = acc[ACC_PAGE];
  assign link.acc_addr  = acc[15:8];
  assign link.acc_wdata = acc[7:0];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      last_read <= 8'h00;
    end else if (gap_start && !acc[ACC_WRITE]) begin
      last_read <= link.acc_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      prev_fault <= 1'b0;
      prev_lost  <= 1'b1;
    end else begin
      prev_fault <= link.laser_fault;
      prev_lost  <= link.receive_signal_lost;
    end
  end

  always_comb begin
    events            = 4'h0;
    events[IRQ_FAULT] = link.laser_fault & ~prev_fault;
    events[IRQ_LOST]  = link.receive_signal_lost & ~prev_lost;
    events[IRQ_FOUND] = ~link.receive_signal_lost & prev_lost;
    events[IRQ_DONE]  = gap_start;
  end

  // Set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_stat <= 4'h0;
    end else if (wr && address == H_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wdata[3:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_mask <= 4'h0;
    end else if (wr && address == H_IRQ_MASK) begin
      irq_mask <= wdata[3:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (address)
        H_CTRL:     rdata <= {28'h0000000, freset, ctrl};
        H_STATUS:   rdata <= {28'h0000000, link.dev_busy, busy,
                              link.receive_signal_lost, link.laser_fault};
        H_IRQ_STAT: rdata <= {28'h0000000, irq_stat};
        H_IRQ_MASK: rdata <= {28'h0000000, irq_mask};
        H_ACCESS:   rdata <= {14'h0000, acc};
        H_RDATA:    rdata <= {24'h000000, last_read};
        default:    rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule : host_end
`default_nettype wire

// ==== verilog/module_end.sv ====
// Optical module end: pins, soft control bytes, serial access slave
//
// How it works
// - Laser modulation returns soon after tx_off drops
// - Init completes and fault clears after restart
// - Hardware fault pin follows detected fault promptly
// - Host holds tx_off high to clear fault
// - Signal-lost pin tracks optical input quickly
// - Speed pin high engages fast recovery
// - Speed pin low bypasses recovery unless its soft speed bit is set
// - Soft off bit kills light after write
// - Clearing soft off restores light
// - Soft fault bit reflects laser fault
// - Soft lost bit tracks optical input
// - Data ready bit follows monitor health
// - Soft speed bits steer each recovery
// - Serial access ready shortly after reset
// - Host leaves idle gap between accesses
// - Writes complete within bounded write cycle
// - Host limits serial access rate
`timescale 1ns/1ps
`default_nettype none
module module_end
  import optic_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   nrst,
  optic_link.device   link,
  input  wire logic   laser_fault_sense,
  input  wire logic   optical_present,
  input  wire logic   monitor_ok,
  output logic        laser_emit,
  output logic        tx_cdr_engage,
  output logic        rx_cdr_engage
);
  logic [1:0] fault_sync;
  logic [1:0] light_sync;
  logic [1:0] mon_sync;
  logic       fault;
  logic       lost;
  logic       data_ready;
  logic       soft_off;
  logic       soft_sp1;
  logic       soft_sp2;
  logic       prev_off;
  logic       eff_off;
  logic       init_start;
  logic       init_done;
  logic       wr_start;
  logic       wr_idle;
  logic       pend_valid;
  logic [7:0] pend_addr;
  logic [7:0] pend_data;
  logic       apply;
  logic       take;
  logic [7:0] status_byte;
  logic [7:0] ext_byte;
  logic [7:0] read_byte;

  // Sense inputs come from analog circuits
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault_sync <= 2'h0;
      light_sync <= 2'h0;
      mon_sync   <= 2'h0;
    end else begin
      fault_sync <= {fault_sync[0], laser_fault_sense};
      light_sync <= {light_sync[0], optical_present};
      mon_sync   <= {mon_sync[0], monitor_ok};
    end
  end

  assign eff_off = link.tx_off | soft_off;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      prev_off <= 1'b1;
    end else begin
      prev_off <= eff_off;
    end
  end

  // Restart initialisation when the transmitter is released
  assign init_start = prev_off & ~eff_off;

  hold_timer #(
    .RESET_COUNT (DEV_INIT_CYC)
  ) init_timer (
    .clock   (clock),
    .nrst    (nrst),
    .start   (init_start),
    .load    (DEV_INIT_CYC),
    .expired (init_done)
  );

  // Fault latch; a new fault wins over the clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault <= 1'b0;
    end else if (fault_sync[1]) begin
      fault <= 1'b1;
    end else if (link.tx_off) begin
      fault <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      laser_emit <= 1'b0;
    end else begin
      laser_emit <= ~eff_off & ~fault & init_done;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      lost <= 1'b1;
    end else begin
      lost <= ~light_sync[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= mon_sync[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rx_cdr_engage <= 1'b0;
      tx_cdr_engage <= 1'b0;
    end else begin
      rx_cdr_engage <= link.speed_choice_first | soft_sp1;
      tx_cdr_engage <= link.speed_choice_second | soft_sp2;
    end
  end

  assign link.laser_fault         = fault;
  assign link.receive_signal_lost = lost;

  // Serial access: busy after reset and during a write cycle
  assign take     = link.acc_valid & ~link.dev_busy;
  assign wr_start = take & link.acc_write & link.acc_page;

  hold_timer #(
    .RESET_COUNT (DEV_READY_CYC)
  ) write_timer (
    .clock   (clock),
    .nrst    (nrst),
    .start   (wr_start),
    .load    (DEV_WRITE_CYC),
    .expired (wr_idle)
  );

  assign link.dev_busy = pend_valid | ~wr_idle;
  assign apply         = pend_valid & wr_idle;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pend_valid <= 1'b0;
      pend_addr  <= 8'h00;
      pend_data  <= 8'h00;
    end else if (wr_start) begin
      pend_valid <= 1'b1;
      pend_addr  <= link.acc_addr;
      pend_data  <= link.acc_wdata;
    end else if (apply) begin
      pend_valid <= 1'b0;
    end
  end

  // Soft controls take effect when the write cycle ends
  always_ff @(posedge clock) begin
    if (!nrst) begin
      soft_off <= 1'b0;
      soft_sp1 <= 1'b0;
    end else if (apply && pend_addr == STATUS_CONTROL_ADDR) begin
      soft_off <= pend_data[SC_SOFT_OFF];
      soft_sp1 <= pend_data[SC_SOFT_SP];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      soft_sp2 <= 1'b0;
    end else if (apply && pend_addr == EXTENDED_CONTROL_ADDR) begin
      soft_sp2 <= pend_data[EC_SOFT_SP];
    end
  end

  always_comb begin
    status_byte               = 8'h00;
    status_byte[SC_TXOFF_PIN] = link.tx_off;
    status_byte[SC_SOFT_OFF]  = soft_off;
    status_byte[SC_SP2_PIN]   = link.speed_choice_second;
    status_byte[SC_SP1_PIN]   = link.speed_choice_first;
    status_byte[SC_SOFT_SP]   = soft_sp1;
    status_byte[SC_FAULT]     = fault;
    status_byte[SC_LOST]      = lost;
    status_byte[SC_READY]     = data_ready;
  end

  always_comb begin
    ext_byte             = 8'h00;
    ext_byte[EC_SOFT_SP] = soft_sp2;
  end

  // Identification page holds only a first byte here
  always_comb begin
    read_byte = 8'h00;
    if (link.acc_page) begin
      if (link.acc_addr == STATUS_CONTROL_ADDR) begin
        read_byte = status_byte;
      end else if (link.acc_addr == EXTENDED_CONTROL_ADDR) begin
        read_byte = ext_byte;
      end
    end else if (link.acc_addr == 8'h00) begin
      read_byte = ID_FIRST_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      link.acc_ack   <= 1'b0;
      link.acc_rdata <= 8'h00;
    end else begin
      link.acc_ack <= take;
      if (take && !link.acc_write) begin
        link.acc_rdata <= read_byte;
      end
    end
  end
endmodule : module_end
`default_nettype wire
